// >>> iep_pkg.sv
// constants shared by the interrupt enable and priority block
package iep_pkg;
    // register addresses and pages
    localparam logic [7:0] ADDR_BASE_PRIO = 8'hb8;
    localparam logic [7:0] ADDR_EXT_EN_ONE = 8'he6;
    localparam logic [7:0] ADDR_EXT_EN_TWO = 8'he7;
    localparam logic [7:0] ADDR_EXT_PRIO_ONE = 8'hf6;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_CONFIG = 8'h0f;
    // reset values and fixed bits
    localparam logic [7:0] BASE_PRIO_RESET = 8'h80;
    localparam logic [7:0] BASE_PRIO_FIXED_ONE = 8'h80;
    localparam logic [7:0] BASE_PRIO_WMASK = 8'h7f;
    localparam logic [7:0] EXT_EN_ONE_RESET = 8'h00;
    localparam logic [7:0] EXT_EN_TWO_RESET = 8'h00;
    localparam logic [7:0] EXT_EN_TWO_WMASK = 8'h05;
    localparam logic [7:0] EXT_PRIO_ONE_RESET = 8'h00;
    // source order numbers; slot 16 has no source
    localparam int NUM_SRC = 18;
    localparam int IDX_W = 5;
    localparam int SRC_EXT0 = 0;
    localparam int SRC_SMB = 7;
    localparam int SRC_REG_DROP = 15;
    localparam int SRC_PORT_MATCH = 17;
    localparam logic [IDX_W-1:0] IDX_NONE = 5'h00;
    // bit positions in the extended enable two register
    localparam int EN2_PORT_MATCH = 2;
    localparam int EN2_REG_DROP = 0;
    typedef logic [NUM_SRC-1:0] iep_src_t;
    typedef logic [IDX_W-1:0] iep_idx_t;
endpackage

// >>> iep_arb_if.sv
// request vectors and winners passed between controller and arbiter
`timescale 1ns/10ps
`default_nettype none
interface iep_arb_if;
    iep_pkg::iep_src_t hi_req;
    iep_pkg::iep_src_t lo_req;
    logic hi_any;
    logic lo_any;
    iep_pkg::iep_idx_t hi_idx;
    iep_pkg::iep_idx_t lo_idx;
    modport ctrl (output hi_req, output lo_req, input hi_any, input lo_any, input hi_idx, input lo_idx);
    modport arb (input hi_req, input lo_req, output hi_any, output lo_any, output hi_idx, output lo_idx);
endinterface
`default_nettype wire

// >>> iep_arbiter.sv
// fixed-order arbiter: lowest source order number wins within each level
`timescale 1ns/10ps
`default_nettype none
module iep_arbiter (
    iep_arb_if.arb arb
);
    // index of the lowest set bit, zero when none is set
    function automatic iep_pkg::iep_idx_t first_set(input iep_pkg::iep_src_t v);
        iep_pkg::iep_idx_t r;
        r = iep_pkg::IDX_NONE;
        for (int i = iep_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = iep_pkg::iep_idx_t'(i);
            end
        end
        return r;
    endfunction

    // same-level ties resolved by source order
    always_comb
    begin
        arb.hi_any = |arb.hi_req;
        arb.lo_any = |arb.lo_req;
        arb.hi_idx = first_set(arb.hi_req);
        arb.lo_idx = first_set(arb.lo_req);
    end
endmodule
`default_nettype wire

// >>> iep_interrupt_ctrl.sv
// interrupt enable and priority registers with two-level request logic
`timescale 1ns/10ps
`default_nettype none
module iep_interrupt_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [2:0] sfr_bit_sel,
    input wire logic sfr_bit_val,
    input wire logic global_irq_enable,
    input wire logic [6:0] base_irq_enable,
    input wire logic [6:0] base_src_pending,
    input wire logic smbus_pending,
    input wire logic adc_window_flag,
    input wire logic adc_done_flag,
    input wire logic counter_array_pending,
    input wire logic comparator_zero_rise_flag,
    input wire logic comparator_zero_fall_flag,
    input wire logic comparator_one_rise_flag,
    input wire logic comparator_one_fall_flag,
    input wire logic timer_three_low_overflow,
    input wire logic timer_three_high_overflow,
    input wire logic lin_pending_flag,
    input wire logic regulator_dropout_pending,
    input wire logic port_match_pending,
    input wire logic regulator_dropout_prio,
    input wire logic port_match_prio,
    input wire logic irq_ack,
    input wire logic irq_return,
    output logic [7:0] sfr_rdata_r,
    output logic sfr_hit_r,
    output logic irq_req_r,
    output logic [4:0] irq_index_r,
    output logic irq_high_r,
    output logic high_active_r,
    output logic low_active_r
);
    logic [7:0] base_interrupt_priority_r, base_interrupt_priority_nxt;
    logic [7:0] extended_interrupt_enable_one_r, extended_interrupt_enable_one_nxt;
    logic [7:0] extended_interrupt_enable_two_r, extended_interrupt_enable_two_nxt;
    logic [7:0] extended_interrupt_priority_one_r, extended_interrupt_priority_one_nxt;
    logic [7:0] sfr_rdata_nxt;
    logic sfr_hit_nxt;
    logic sel_base_prio, sel_en_one, sel_en_two, sel_prio_one;
    logic prio_one_page_ok;
    iep_pkg::iep_src_t pending, enables, prio, gated;
    logic irq_req_nxt, irq_high_nxt, high_active_nxt, low_active_nxt;
    logic [4:0] irq_index_nxt;
    iep_arb_if arb_bus ();

    iep_arbiter u_arbiter (
        .arb(arb_bus)
    );

    // address decode: paged register only on its two pages
    always_comb
    begin
        prio_one_page_ok = (sfr_page == iep_pkg::PAGE_ZERO) || (sfr_page == iep_pkg::PAGE_CONFIG);
        sel_base_prio = (sfr_addr == iep_pkg::ADDR_BASE_PRIO);
        sel_en_one = (sfr_addr == iep_pkg::ADDR_EXT_EN_ONE);
        sel_en_two = (sfr_addr == iep_pkg::ADDR_EXT_EN_TWO);
        sel_prio_one = (sfr_addr == iep_pkg::ADDR_EXT_PRIO_ONE) && prio_one_page_ok;
    end

    // register writes; byte writes and single-bit writes to base priority
    always_comb
    begin
        base_interrupt_priority_nxt = base_interrupt_priority_r;
        extended_interrupt_enable_one_nxt = extended_interrupt_enable_one_r;
        extended_interrupt_enable_two_nxt = extended_interrupt_enable_two_r;
        extended_interrupt_priority_one_nxt = extended_interrupt_priority_one_r;
        if (sfr_wr && sel_base_prio)
        begin
            base_interrupt_priority_nxt = (sfr_wdata & iep_pkg::BASE_PRIO_WMASK) | iep_pkg::BASE_PRIO_FIXED_ONE;
        end
        else if (sfr_bit_wr && sel_base_prio)
        begin
            base_interrupt_priority_nxt[sfr_bit_sel] = sfr_bit_val;
            base_interrupt_priority_nxt = base_interrupt_priority_nxt | iep_pkg::BASE_PRIO_FIXED_ONE;
        end
        if (sfr_wr && sel_en_one)
        begin
            extended_interrupt_enable_one_nxt = sfr_wdata;
        end
        if (sfr_wr && sel_en_two)
        begin
            extended_interrupt_enable_two_nxt = sfr_wdata & iep_pkg::EXT_EN_TWO_WMASK;
        end
        if (sfr_wr && sel_prio_one)
        begin
            extended_interrupt_priority_one_nxt = sfr_wdata;
        end
    end

    // register state
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            base_interrupt_priority_r <= iep_pkg::BASE_PRIO_RESET;
            extended_interrupt_enable_one_r <= iep_pkg::EXT_EN_ONE_RESET;
            extended_interrupt_enable_two_r <= iep_pkg::EXT_EN_TWO_RESET;
            extended_interrupt_priority_one_r <= iep_pkg::EXT_PRIO_ONE_RESET;
        end
        else
        begin
            base_interrupt_priority_r <= base_interrupt_priority_nxt;
            extended_interrupt_enable_one_r <= extended_interrupt_enable_one_nxt;
            extended_interrupt_enable_two_r <= extended_interrupt_enable_two_nxt;
            extended_interrupt_priority_one_r <= extended_interrupt_priority_one_nxt;
        end
    end

    // read mux; data appears one cycle after the read strobe
    always_comb
    begin
        sfr_rdata_nxt = 8'h00;
        sfr_hit_nxt = 1'b0;
        if (sfr_rd)
        begin
            sfr_hit_nxt = sel_base_prio || sel_en_one || sel_en_two || sel_prio_one;
            if (sel_base_prio)
            begin
                sfr_rdata_nxt = base_interrupt_priority_r | iep_pkg::BASE_PRIO_FIXED_ONE;
            end
            else if (sel_en_one)
            begin
                sfr_rdata_nxt = extended_interrupt_enable_one_r;
            end
            else if (sel_en_two)
            begin
                sfr_rdata_nxt = extended_interrupt_enable_two_r & iep_pkg::EXT_EN_TWO_WMASK;
            end
            else if (sel_prio_one)
            begin
                sfr_rdata_nxt = extended_interrupt_priority_one_r;
            end
        end
    end

    // read data registers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sfr_rdata_r <= 8'h00;
            sfr_hit_r <= 1'b0;
        end
        else
        begin
            sfr_rdata_r <= sfr_rdata_nxt;
            sfr_hit_r <= sfr_hit_nxt;
        end
    end

    // source vectors in fixed order; slot 16 stays empty
    always_comb
    begin
        pending = '0;
        enables = '0;
        prio = '0;
        pending[6:0] = base_src_pending;
        enables[6:0] = base_irq_enable;
        prio[6:0] = base_interrupt_priority_r[6:0];
        pending[7] = smbus_pending;
        pending[8] = adc_window_flag;
        pending[9] = adc_done_flag;
        pending[10] = counter_array_pending;
        pending[11] = comparator_zero_rise_flag || comparator_zero_fall_flag;
        pending[12] = comparator_one_rise_flag || comparator_one_fall_flag;
        pending[13] = timer_three_low_overflow || timer_three_high_overflow;
        pending[14] = lin_pending_flag;
        // enable-one and priority-one bit i map onto source 7+i
        for (int i = 0; i < 8; i++)
        begin
            enables[iep_pkg::SRC_SMB + i] = extended_interrupt_enable_one_r[i];
            prio[iep_pkg::SRC_SMB + i] = extended_interrupt_priority_one_r[i];
        end
        pending[iep_pkg::SRC_REG_DROP] = regulator_dropout_pending;
        pending[iep_pkg::SRC_PORT_MATCH] = port_match_pending;
        enables[iep_pkg::SRC_REG_DROP] = extended_interrupt_enable_two_r[iep_pkg::EN2_REG_DROP];
        enables[iep_pkg::SRC_PORT_MATCH] = extended_interrupt_enable_two_r[iep_pkg::EN2_PORT_MATCH];
        prio[iep_pkg::SRC_REG_DROP] = regulator_dropout_prio;
        prio[iep_pkg::SRC_PORT_MATCH] = port_match_prio;
        gated = global_irq_enable ? (pending & enables) : '0;
        arb_bus.hi_req = gated & prio;
        arb_bus.lo_req = gated & ~prio;
    end

    // request and in-service levels; an ack in the same cycle as a return wins
    always_comb
    begin
        high_active_nxt = high_active_r;
        low_active_nxt = low_active_r;
        if (irq_return)
        begin
            if (high_active_r)
            begin
                high_active_nxt = 1'b0;
            end
            else
            begin
                low_active_nxt = 1'b0;
            end
        end
        if (irq_ack && irq_req_r)
        begin
            if (irq_high_r)
            begin
                high_active_nxt = 1'b1;
            end
            else
            begin
                low_active_nxt = 1'b1;
            end
        end
        irq_req_nxt = 1'b0;
        irq_high_nxt = 1'b0;
        irq_index_nxt = iep_pkg::IDX_NONE;
        if (arb_bus.hi_any && !high_active_nxt)
        begin
            irq_req_nxt = 1'b1;
            irq_high_nxt = 1'b1;
            irq_index_nxt = arb_bus.hi_idx;
        end
        else if (arb_bus.lo_any && !high_active_nxt && !low_active_nxt)
        begin
            irq_req_nxt = 1'b1;
            irq_index_nxt = arb_bus.lo_idx;
        end
    end

    // request state
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            irq_req_r <= 1'b0;
            irq_high_r <= 1'b0;
            irq_index_r <= iep_pkg::IDX_NONE;
            high_active_r <= 1'b0;
            low_active_r <= 1'b0;
        end
        else
        begin
            irq_req_r <= irq_req_nxt;
            irq_high_r <= irq_high_nxt;
            irq_index_r <= irq_index_nxt;
            high_active_r <= high_active_nxt;
            low_active_r <= low_active_nxt;
        end
    end

    // checks on the register map and request logic
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence base_read_s;
        sfr_rd && sfr_addr == iep_pkg::ADDR_BASE_PRIO;
    endsequence

    base_bit_one_a: assert property (base_read_s |=> sfr_rdata_r[7] && sfr_hit_r)
        else $error("base priority bit 7 did not read as one");
    base_write_mask_a: assert property (sfr_wr && sfr_addr == iep_pkg::ADDR_BASE_PRIO
        |=> base_interrupt_priority_r[6:0] == $past(sfr_wdata[6:0]))
        else $error("base priority write not stored");
    en_two_unused_a: assert property (sfr_rd && sfr_addr == iep_pkg::ADDR_EXT_EN_TWO
        |=> (sfr_rdata_r & ~iep_pkg::EXT_EN_TWO_WMASK) == 8'h00)
        else $error("enable two unused bits read nonzero");
    prio_one_page_a: assert property (sfr_wr && sfr_addr == iep_pkg::ADDR_EXT_PRIO_ONE && !prio_one_page_ok
        |=> $stable(extended_interrupt_priority_one_r))
        else $error("priority one written on a foreign page");
    en_one_write_a: assert property (sfr_wr && sfr_addr == iep_pkg::ADDR_EXT_EN_ONE
        |=> extended_interrupt_enable_one_r == $past(sfr_wdata))
        else $error("enable one write not stored");
    global_block_a: assert property (!global_irq_enable [*2] |=> !irq_req_r)
        else $error("request raised while globally disabled");
    low_no_preempt_a: assert property ((high_active_r || low_active_r) && irq_req_r |-> irq_high_r && !high_active_r)
        else $error("low request preempted a running handler");
    high_preempt_a: assert property (global_irq_enable && arb_bus.hi_any && !high_active_r && !irq_ack
        |=> irq_req_r && irq_high_r)
        else $error("high request did not preempt");
    lowest_order_a: assert property (irq_req_r && irq_high_r |-> irq_index_r == $past(arb_bus.hi_idx))
        else $error("high request index not lowest order");
    lin_gate_a: assert property (global_irq_enable && lin_pending_flag && extended_interrupt_enable_one_r[7]
        && !high_active_r && !low_active_r && !irq_ack && !irq_return |=> irq_req_r)
        else $error("enabled lin request not raised");
endmodule
`default_nettype wire

// >>> iep_cpu_model.sv
// cpu side model: takes standing requests after a set delay
`timescale 1ns/10ps
`default_nettype none
module iep_cpu_model (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic irq_req_r,
    input wire logic [4:0] irq_index_r,
    output logic irq_ack,
    output logic [4:0] taken_idx
);
    logic [3:0] wait_cnt;
    // count cycles of a standing request, then pulse ack once and note the source taken
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            irq_ack <= 1'b0;
            wait_cnt <= 4'h0;
            taken_idx <= 5'h00;
        end
        else
        begin
            irq_ack <= 1'b0;
            if (irq_ack && irq_req_r)
                taken_idx <= irq_index_r;
            if (!irq_req_r || irq_ack)
                wait_cnt <= 4'h0;
            else if (ack_en && wait_cnt >= ack_wait)
                irq_ack <= 1'b1;
            else
                wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// >>> iep_interrupt_ctrl_tb_top.sv
// self-checking bench for the interrupt enable and priority registers
`timescale 1ns/10ps
`default_nettype none
module iep_interrupt_ctrl_tb_top;
    logic sys_clk;
    logic reset;
    logic [7:0] sfr_addr;
    logic [7:0] sfr_page;
    logic [7:0] sfr_wdata;
    logic sfr_wr;
    logic sfr_rd;
    logic sfr_bit_wr;
    logic [2:0] sfr_bit_sel;
    logic sfr_bit_val;
    logic global_irq_enable;
    logic [6:0] base_irq_enable;
    logic [17:0] pend;
    logic alt;
    logic reg_prio;
    logic port_prio;
    logic irq_ack;
    logic irq_return;
    logic ack_en;
    logic [3:0] ack_wait;
    logic [4:0] taken_idx;
    logic [7:0] rdata;
    logic hit;
    logic req;
    logic [4:0] idx;
    logic high;
    logic hact;
    logic lact;
    logic [7:0] base_m;
    logic [7:0] en1_m;
    logic [7:0] en2_m;
    logic [7:0] pr1_m;
    logic [31:0] seed;
    int mismatches;
    int cmp_count;
    int cycles;

    iep_interrupt_ctrl iep_interrupt_ctrl_i (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
        .sfr_bit_wr(sfr_bit_wr), .sfr_bit_sel(sfr_bit_sel), .sfr_bit_val(sfr_bit_val),
        .global_irq_enable(global_irq_enable), .base_irq_enable(base_irq_enable),
        .base_src_pending(pend[6:0]), .smbus_pending(pend[7]), .adc_window_flag(pend[8]),
        .adc_done_flag(pend[9]), .counter_array_pending(pend[10]),
        .comparator_zero_rise_flag(pend[11] & alt), .comparator_zero_fall_flag(pend[11] & ~alt),
        .comparator_one_rise_flag(pend[12] & alt), .comparator_one_fall_flag(pend[12] & ~alt),
        .timer_three_low_overflow(pend[13] & alt), .timer_three_high_overflow(pend[13] & ~alt),
        .lin_pending_flag(pend[14]), .regulator_dropout_pending(pend[15]),
        .port_match_pending(pend[17]), .regulator_dropout_prio(reg_prio), .port_match_prio(port_prio),
        .irq_ack(irq_ack), .irq_return(irq_return), .sfr_rdata_r(rdata), .sfr_hit_r(hit),
        .irq_req_r(req), .irq_index_r(idx), .irq_high_r(high), .high_active_r(hact), .low_active_r(lact));

    iep_cpu_model iep_cpu_model_i (.sys_clk(sys_clk), .reset(reset), .ack_en(ack_en), .ack_wait(ack_wait),
        .irq_req_r(req), .irq_index_r(idx), .irq_ack(irq_ack), .taken_idx(taken_idx));

    // clock at 50 ns
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            complete_run();
        end
    end

    // xorshift source of stimulus
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // {enable, high level} of one source
    function automatic logic [1:0] cfg(input int s);
        if (s < 7)
            return {base_irq_enable[s], base_m[s]};
        if (s < 15)
            return {en1_m[s-7], pr1_m[s-7]};
        if (s == 15)
            return {en2_m[0], reg_prio};
        return {en2_m[2], port_prio};
    endfunction

    // expected {request, high, index} with nothing in service
    function automatic logic [6:0] expect_irq();
        logic [1:0] c;
        logic [6:0] lo;
        logic [6:0] hi;
        lo = 7'h00;
        hi = 7'h00;
        for (int s = 17; s >= 0; s--)
        begin
            c = cfg(s);
            if (s != 16 && pend[s] && global_irq_enable && c[1])
            begin
                if (c[0])
                    hi = {2'b11, 5'(s)};
                else
                    lo = {2'b10, 5'(s)};
            end
        end
        return hi[6] ? hi : lo;
    endfunction

    // compare tasks
    task automatic chk_reg(input string what, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic chk_irq(input string what, input logic [6:0] exp, input logic [6:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // byte write, keeping the register model in step
    task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge sys_clk);
        sfr_wr <= 1'b0;
        if (a == iep_pkg::ADDR_BASE_PRIO)
            base_m = iep_pkg::BASE_PRIO_FIXED_ONE | (d & iep_pkg::BASE_PRIO_WMASK);
        if (a == iep_pkg::ADDR_EXT_EN_ONE)
            en1_m = d;
        if (a == iep_pkg::ADDR_EXT_EN_TWO)
            en2_m = d & iep_pkg::EXT_EN_TWO_WMASK;
        if (a == iep_pkg::ADDR_EXT_PRIO_ONE && (p == 8'h00 || p == 8'h0f))
            pr1_m = d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [8:0] exp);
        @(posedge sys_clk);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_rd <= 1'b1;
        @(posedge sys_clk);
        sfr_rd <= 1'b0;
        #1;
        chk_reg($sformatf("read %h page %h", a, p), exp, {hit, rdata});
    endtask

    // read every register plus an unmapped address
    task automatic rd_all(input logic [7:0] p);
        rd(iep_pkg::ADDR_BASE_PRIO, p, {1'b1, base_m});
        rd(iep_pkg::ADDR_EXT_EN_ONE, p, {1'b1, en1_m});
        rd(iep_pkg::ADDR_EXT_EN_TWO, p, {1'b1, en2_m});
        rd(iep_pkg::ADDR_EXT_PRIO_ONE, p, (p == 8'h00 || p == 8'h0f) ? {1'b1, pr1_m} : 9'h000);
        rd(8'hf7, p, 9'h000);
    endtask

    task automatic irq_check();
        @(posedge sys_clk);
        #1;
        chk_irq("request", expect_irq(), {req, high & req, idx & {5{req}}});
        @(posedge sys_clk); // next stimulus lands on a rising edge
    endtask

    task automatic wait_active(input logic hi_lvl);
        for (int n = 0; n < 30 && !(hi_lvl ? hact : lact); n++)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    task automatic ret_pulse(input logic [6:0] exp);
        @(posedge sys_clk);
        irq_return <= 1'b1;
        @(posedge sys_clk);
        irq_return <= 1'b0;
        #1;
        chk_irq("active levels", exp, {5'h00, hact, lact});
    endtask

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // main sequence
    initial
    begin
        {sfr_addr, sfr_page, sfr_wdata, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_sel, sfr_bit_val} = '0;
        {global_irq_enable, base_irq_enable, pend, alt, reg_prio, port_prio, irq_return, ack_en} = '0;
        ack_wait = 4'h0;
        seed = 32'h0000001e;
        reset = 1'b1;
        base_m = iep_pkg::BASE_PRIO_RESET;
        en1_m = iep_pkg::EXT_EN_ONE_RESET;
        en2_m = iep_pkg::EXT_EN_TWO_RESET;
        pr1_m = iep_pkg::EXT_PRIO_ONE_RESET;
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        rd_all(8'h00);
        for (int i = 0; i < 24; i++)
        begin
            // stray write to an unmapped address must leave every register alone
            wr(8'hf7, 8'(rnd()), 8'(rnd()));
            wr(8'he6 + 8'(rnd() % 2), 8'(rnd() % 3 == 0 ? 8'h0f : rnd()), 8'(rnd()));
            wr(iep_pkg::ADDR_EXT_PRIO_ONE, (rnd() % 2) ? 8'h00 : 8'(rnd()), 8'(rnd()));
            wr(iep_pkg::ADDR_BASE_PRIO, 8'(rnd()), 8'(rnd()));
            rd_all((rnd() % 2) ? 8'h0f : 8'(rnd()));
        end
        $display("test register access done");
        for (int i = 0; i < 16; i++)
        begin
            @(posedge sys_clk);
            sfr_addr <= iep_pkg::ADDR_BASE_PRIO;
            sfr_page <= 8'(rnd());
            sfr_bit_sel <= 3'(i);
            sfr_bit_val <= 1'(rnd());
            sfr_bit_wr <= 1'b1;
            @(posedge sys_clk);
            sfr_bit_wr <= 1'b0;
            if (i % 8 != 7)
                base_m[i%8] = sfr_bit_val;
            rd(iep_pkg::ADDR_BASE_PRIO, 8'h0f, {1'b1, base_m});
        end
        $display("test bit writes done");
        wr(iep_pkg::ADDR_EXT_EN_ONE, 8'h00, 8'hff);
        wr(iep_pkg::ADDR_EXT_EN_TWO, 8'h00, 8'hff);
        base_irq_enable <= 7'h7f;
        global_irq_enable <= 1'b1;
        for (int s = 0; s < 18; s++)
        begin
            wr(iep_pkg::ADDR_BASE_PRIO, 8'h00, 8'(rnd()));
            wr(iep_pkg::ADDR_EXT_PRIO_ONE, 8'h0f, 8'(rnd()));
            reg_prio <= 1'(rnd());
            port_prio <= 1'(rnd());
            alt <= 1'(s / 2);
            pend <= (s == 16) ? 18'h00000 : 18'h00001 << s;
            irq_check();
            global_irq_enable <= 1'b0;
            irq_check();
            global_irq_enable <= 1'b1;
        end
        pend <= 18'h2ffff;
        wr(iep_pkg::ADDR_EXT_PRIO_ONE, 8'h00, 8'hff);
        wr(iep_pkg::ADDR_BASE_PRIO, 8'h00, 8'h00);
        irq_check();
        $display("test single sources done");
        for (int i = 0; i < 40; i++)
        begin
            wr(8'he6 + 8'(rnd() % 2), 8'h00, 8'(rnd()));
            wr(iep_pkg::ADDR_EXT_PRIO_ONE, 8'h00, 8'(rnd()));
            wr(iep_pkg::ADDR_BASE_PRIO, 8'h00, 8'(rnd()));
            base_irq_enable <= 7'(rnd());
            global_irq_enable <= (rnd() % 4 != 0);
            {reg_prio, port_prio, alt} <= 3'(rnd());
            pend <= 18'(rnd()) & 18'h2ffff;
            irq_check();
        end
        $display("test random mix done");
        wr(iep_pkg::ADDR_EXT_EN_ONE, 8'h00, 8'hff);
        wr(iep_pkg::ADDR_EXT_PRIO_ONE, 8'h00, 8'h00);
        global_irq_enable <= 1'b1;
        pend <= 18'h04000;
        ack_wait <= 4'h3;
        ack_en <= 1'b1;
        wait_active(1'b0);
        @(posedge sys_clk);
        pend <= 18'h04080;
        repeat (3) @(posedge sys_clk);
        #1;
        chk_irq("low under low", 7'h01, {req, 4'h0, hact, lact});
        wr(iep_pkg::ADDR_EXT_PRIO_ONE, 8'h00, 8'h01);
        wait_active(1'b1);
        chk_irq("preempting source", 7'h07, {2'b00, taken_idx});
        @(posedge sys_clk);
        pend <= 18'h00000;
        ret_pulse(7'h01);
        ret_pulse(7'h00);
        $display("test preemption done");
        complete_run();
    end
endmodule
`default_nettype wire
